/* File: hw/sleep_wake_map.svh */
// Constants for the sleep and wake signalling block
`ifndef SLEEP_WAKE_MAP_SVH
`define SLEEP_WAKE_MAP_SVH

`define CLK_FREQ_HZ       40000000
`define WAKE_PULSE_MS     1000
`define WAKE_PULSE_CYCLES ((`CLK_FREQ_HZ / 1000) * `WAKE_PULSE_MS)
`define FILTER_CYCLES     4
`define FILTER_W          3
`define PULSE_CNT_W       26

`endif

/* File: hw/sleep_wake_pkg.sv */
// Types for the sleep and wake signalling block
package sleep_wake_pkg;

  typedef enum logic [1:0] {
    ST_BOOT   = 2'b00,
    ST_AWAKE  = 2'b01,
    ST_ALLOW  = 2'b10
  } sleep_state_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } edge_info_t;

endpackage

/* File: hw/level_filter.sv */
// Synchroniser, glitch filter and edge detector for the sleep-request level
`timescale 1ns/10ps
`default_nettype none
`include "sleep_wake_map.svh"

module level_filter
(
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     reset_n_i,
  // Raw level
  input  wire logic                     level_i,
  // Filtered level and edges
  output var sleep_wake_pkg::edge_info_t info_o
);

  logic                     sync1_reg;
  logic                     sync2_reg;
  logic                     stable_reg;
  logic                     stable_next;
  logic [`FILTER_W-1:0]     cnt_reg;
  logic [`FILTER_W-1:0]     cnt_next;
  sleep_wake_pkg::edge_info_t info_reg;
  sleep_wake_pkg::edge_info_t info_next;

  // Filter: new level accepted after FILTER_CYCLES agreeing samples
  always_comb
  begin
    stable_next = stable_reg;
    cnt_next    = '0;
    if (sync2_reg != stable_reg)
    begin
      if (cnt_reg == `FILTER_W'(`FILTER_CYCLES - 1))
      begin
        stable_next = sync2_reg;
      end
      else
      begin
        cnt_next = cnt_reg + `FILTER_W'(1);
      end
    end
    info_next.level = stable_next;
    info_next.rise  = stable_next & ~stable_reg;
    info_next.fall  = ~stable_next & stable_reg;
  end

  // Registers; level resets high as the idle, awake value
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      sync1_reg  <= 1'b1;
      sync2_reg  <= 1'b1;
      stable_reg <= 1'b1;
      cnt_reg    <= '0;
      info_reg   <= 3'b100;
    end
    else
    begin
      sync1_reg  <= level_i;
      sync2_reg  <= sync1_reg;
      stable_reg <= stable_next;
      cnt_reg    <= cnt_next;
      info_reg   <= info_next;
    end
  end

  assign info_o = info_reg;

endmodule // level_filter
`default_nettype wire

/* File: hw/sleep_wake_signalling.sv */
// Sleep permission and host wake pulse control
`timescale 1ns/10ps
`default_nettype none
`include "sleep_wake_map.svh"

module sleep_wake_signalling
(
  // Clock and reset
  input  wire logic     clock_i,
  input  wire logic     reset_n_i,
  // Power-up sequencing
  input  wire logic     power_up_done_i,
  // Host sleep request level
  input  wire logic     sleep_req_i,
  // Modem events
  input  wire logic     call_event_i,
  input  wire logic     msg_event_i,
  // Status and host wake
  output logic          sleep_allowed_o,
  output logic          host_wake_o
);

  sleep_wake_pkg::edge_info_t   req_info;
  sleep_wake_pkg::sleep_state_t state_reg;
  sleep_wake_pkg::sleep_state_t state_next;
  logic                         allowed_reg;
  logic                         allowed_next;
  logic [`PULSE_CNT_W-1:0]      pulse_cnt_reg;
  logic [`PULSE_CNT_W-1:0]      pulse_cnt_next;
  logic                         wake_reg;
  logic                         wake_next;
  logic                         event_hit;

  // Request input conditioning
  level_filter u_filter
  (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .level_i   (sleep_req_i),
    .info_o    (req_info)
  );

  // Sleep permission state machine
  always_comb
  begin
    state_next   = state_reg;
    allowed_next = allowed_reg;
    unique case (state_reg)
      sleep_wake_pkg::ST_BOOT:
      begin
        if (power_up_done_i)
        begin
          if (!req_info.level)
          begin
            state_next   = sleep_wake_pkg::ST_ALLOW;
            allowed_next = 1'b1;
          end
          else
          begin
            state_next   = sleep_wake_pkg::ST_AWAKE;
          end
        end
      end
      sleep_wake_pkg::ST_AWAKE:
      begin
        if (req_info.fall)
        begin
          state_next   = sleep_wake_pkg::ST_ALLOW;
          allowed_next = 1'b1;
        end
      end
      sleep_wake_pkg::ST_ALLOW:
      begin
        if (req_info.rise)
        begin
          state_next   = sleep_wake_pkg::ST_AWAKE;
          allowed_next = 1'b0;
        end
      end
      default:
      begin
        state_next   = sleep_wake_pkg::ST_BOOT;
        allowed_next = 1'b0;
      end
    endcase
  end

  // Sleep permission registers
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      state_reg   <= sleep_wake_pkg::ST_BOOT;
      allowed_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      allowed_reg <= allowed_next;
    end
  end

  // Wake pulse: load full count on any event, else count down
  always_comb
  begin
    event_hit      = call_event_i | msg_event_i;
    pulse_cnt_next = pulse_cnt_reg;
    wake_next      = wake_reg;
    if (event_hit)
    begin
      pulse_cnt_next = `PULSE_CNT_W'(`WAKE_PULSE_CYCLES - 1);
      wake_next      = 1'b1;
    end
    else if (pulse_cnt_reg != '0)
    begin
      pulse_cnt_next = pulse_cnt_reg - `PULSE_CNT_W'(1);
    end
    else
    begin
      wake_next      = 1'b0;
    end
  end

  // Wake pulse registers
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      pulse_cnt_reg <= '0;
      wake_reg      <= 1'b0;
    end
    else
    begin
      pulse_cnt_reg <= pulse_cnt_next;
      wake_reg      <= wake_next;
    end
  end

  assign sleep_allowed_o = allowed_reg;
  assign host_wake_o     = wake_reg;

  // Checks
  property p_fall_allows;
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == sleep_wake_pkg::ST_AWAKE && req_info.fall) |=> sleep_allowed_o;
  endproperty
  a_fall_allows: assert property (p_fall_allows) else $error("fall did not allow sleep");

  property p_rise_exits;
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == sleep_wake_pkg::ST_ALLOW && req_info.rise) |=> !sleep_allowed_o;
  endproperty
  a_rise_exits: assert property (p_rise_exits) else $error("rise did not exit sleep");

  property p_boot_low;
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == sleep_wake_pkg::ST_BOOT && power_up_done_i && !req_info.level)
      |=> sleep_allowed_o;
  endproperty
  a_boot_low: assert property (p_boot_low) else $error("low at boot ignored");

  property p_boot_high;
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == sleep_wake_pkg::ST_BOOT && power_up_done_i && req_info.level)
      |=> !sleep_allowed_o;
  endproperty
  a_boot_high: assert property (p_boot_high) else $error("high at boot allowed sleep");

  property p_event_pulse;
    @(posedge clock_i) disable iff (!reset_n_i)
    event_hit |=> host_wake_o && pulse_cnt_reg == `PULSE_CNT_W'(`WAKE_PULSE_CYCLES - 1);
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("event gave no pulse");

  property p_retrigger;
    @(posedge clock_i) disable iff (!reset_n_i)
    (host_wake_o && event_hit) |=> pulse_cnt_reg == `PULSE_CNT_W'(`WAKE_PULSE_CYCLES - 1);
  endproperty
  a_retrigger: assert property (p_retrigger) else $error("pulse not restarted");

  property p_low_idle;
    @(posedge clock_i) disable iff (!reset_n_i)
    (pulse_cnt_reg == '0 && !event_hit) |=> !host_wake_o;
  endproperty
  a_low_idle: assert property (p_low_idle) else $error("wake high with no event");

  property p_count_down;
    @(posedge clock_i) disable iff (!reset_n_i)
    (pulse_cnt_reg != '0 && !event_hit) |=> pulse_cnt_reg == $past(pulse_cnt_reg) - 1'b1;
  endproperty
  a_count_down: assert property (p_count_down) else $error("pulse count stuck");

  property p_boot_wait;
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == sleep_wake_pkg::ST_BOOT && !power_up_done_i) |=> !sleep_allowed_o;
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("sleep allowed before power-up");

  property p_awake_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == sleep_wake_pkg::ST_AWAKE && !req_info.fall) |=> !sleep_allowed_o;
  endproperty
  a_awake_hold: assert property (p_awake_hold) else $error("sleep allowed with no fall");

  property p_allow_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
    (state_reg == sleep_wake_pkg::ST_ALLOW && !req_info.rise) |=> sleep_allowed_o;
  endproperty
  a_allow_hold: assert property (p_allow_hold) else $error("sleep left with no rise");

  property p_wake_held;
    @(posedge clock_i) disable iff (!reset_n_i)
    (host_wake_o && pulse_cnt_reg != '0) |=> host_wake_o;
  endproperty
  a_wake_held: assert property (p_wake_held) else $error("wake pulse cut short");

  property p_wake_stays_low;
    @(posedge clock_i) disable iff (!reset_n_i)
    (!host_wake_o && !event_hit) |=> !host_wake_o;
  endproperty
  a_wake_stays_low: assert property (p_wake_stays_low) else $error("wake rose with no event");

endmodule // sleep_wake_signalling
`default_nettype wire

/* File: test/host_model.sv */
// Host model driving the sleep request and counting wake pulses
`timescale 1ns/10ps
`default_nettype none

module host_model
(
  // Clock
  input  wire logic clock_i,
  // Wake line from the module
  input  wire logic host_wake_i,
  // Sleep request level toward the module
  output var logic  sleep_req_o
);
  int   wake_count = 0;
  logic wake_last  = 1'b0;

  // Request idles high, meaning awake
  initial sleep_req_o = 1'b1;

  // Count rising edges of the wake line
  always @(posedge clock_i)
  begin
    if (host_wake_i && !wake_last)
      wake_count <= wake_count + 1;
    wake_last <= host_wake_i;
  end

  // Set a level after an edge, then hold it for n edges
  task automatic drive(input logic lvl, input int n);
    @(posedge clock_i);
    sleep_req_o <= lvl;
    repeat (n) @(posedge clock_i);
  endtask
endmodule // host_model

`default_nettype wire

/* File: test/sleep_wake_signalling_test.sv */
// Self-checking bench for the sleep and wake signalling block
`timescale 1ns/10ps
`default_nettype none
`include "sleep_wake_map.svh"

module sleep_wake_signalling_test;
  logic clock_i         = 1'b0;
  logic reset_n_i       = 1'b0;
  logic power_up_done_i = 1'b0;
  logic call_event_i    = 1'b0;
  logic msg_event_i     = 1'b0;
  logic sleep_req;
  logic sleep_allowed_o;
  logic host_wake_o;
  int   bad_count       = 0;
  int   cmp_count       = 0;

  // Free-running 40 MHz clock
  always #12.5 clock_i = ~clock_i;

  sleep_wake_signalling u_dut
  (
    .clock_i         (clock_i),
    .reset_n_i       (reset_n_i),
    .power_up_done_i (power_up_done_i),
    .sleep_req_i     (sleep_req),
    .call_event_i    (call_event_i),
    .msg_event_i     (msg_event_i),
    .sleep_allowed_o (sleep_allowed_o),
    .host_wake_o     (host_wake_o)
  );

  host_model u_host
  (
    .clock_i     (clock_i),
    .host_wake_i (host_wake_o),
    .sleep_req_o (sleep_req)
  );

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts and verdict
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Bounded wait for the sleep status to reach a level
  task automatic settle(input logic exp);
    int i;
    i = 0;
    #1;
    while (i < 20 && sleep_allowed_o !== exp)
    begin
      @(posedge clock_i);
      #1;
      i++;
    end
    check(sleep_allowed_o, exp);
    if (sleep_allowed_o !== exp)
      end_sim();
  endtask

  // Request low before power-up completes; reset held two edges
  task automatic t_boot();
    u_host.drive(1'b0, 1);
    reset_n_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    #1;
    check(sleep_allowed_o, 1'b0);
    @(posedge clock_i);
    power_up_done_i <= 1'b1;
    settle(1'b1);
    $display("boot test done");
  endtask

  // Edges, and a glitch that must be ignored
  task automatic t_level();
    u_host.drive(1'b1, 0);
    settle(1'b0);
    u_host.drive(1'b0, 1);
    u_host.drive(1'b1, 20);
    #1;
    check(sleep_allowed_o, 1'b0);
    u_host.drive(1'b0, 0);
    settle(1'b1);
    u_host.drive(1'b1, 0);
    settle(1'b0);
    $display("level test done");
  endtask

  // Wake pulse, retrigger, and reset in mid-pulse
  task automatic t_wake();
    #1;
    check(host_wake_o, 1'b0);
    @(posedge clock_i);
    call_event_i <= 1'b1;
    @(posedge clock_i);
    call_event_i <= 1'b0;
    #1;
    check(host_wake_o, 1'b1);
    check(u_dut.pulse_cnt_reg, `WAKE_PULSE_CYCLES - 1);
    repeat (500) @(posedge clock_i);
    msg_event_i <= 1'b1;
    @(posedge clock_i);
    msg_event_i <= 1'b0;
    repeat (500) @(posedge clock_i);
    #1;
    check(host_wake_o, 1'b1);
    check(u_dut.pulse_cnt_reg, `WAKE_PULSE_CYCLES - 501);
    check(u_host.wake_count, 32'h0000_0001);
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    #1;
    check(host_wake_o, 1'b0);
    check(sleep_allowed_o, 1'b0);
    repeat (2) @(posedge clock_i);
    #1;
    check(host_wake_o, 1'b0);
    check(sleep_allowed_o, 1'b0);
    u_host.drive(1'b0, 0);
    settle(1'b1);
    $display("wake test done");
  endtask

  // Main sequence
  initial
  begin
    t_boot();
    t_level();
    t_wake();
    end_sim();
  end
endmodule // sleep_wake_signalling_test

`default_nettype wire
